// [design/supervisor_pkg.sv]
package supervisor_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned RESET_STRETCH_MS = 200;
  localparam int unsigned BROWNOUT_EXT_MS  = 140;
  localparam int unsigned WATCHDOG_MS      = 1600;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned MS_DIV         = CLK_HZ / 1000;
  localparam logic [CNT_W-1:0] MS_DIV_LAST = CNT_W'(MS_DIV - 1);
  localparam logic [15:0] RESET_STRETCH_TICKS = 16'(RESET_STRETCH_MS);
  localparam logic [15:0] BROWNOUT_EXT_TICKS  = 16'(BROWNOUT_EXT_MS);
  localparam logic [15:0] WATCHDOG_TICKS      = 16'(WATCHDOG_MS);
  localparam logic [15:0] TICKS_ZERO          = 16'h0000;
  localparam logic [15:0] TICK_ONE            = 16'h0001;
  localparam logic [CNT_W-1:0] DIV_ZERO       = 32'h0000_0000;
  localparam logic [CNT_W-1:0] DIV_ONE        = 32'h0000_0001;
  localparam logic [1:0]  SYNC_RESET          = 2'h0;
endpackage : supervisor_pkg

// [design/sync_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface sync_if;
  logic d;
  logic q;
  modport src (output d, input q);
  modport dst (input d, output q);
endinterface : sync_if
`default_nettype wire

// [design/bit_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module bit_sync
  import supervisor_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic nrst_in,
  sync_if.dst       s
);
  typedef struct packed {
    logic [1:0] stage;
  } sync_state_t;
  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.stage = {st_q.stage[0], s.d};
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q.stage <= SYNC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign s.q = st_q.stage[1];
endmodule // bit_sync
`default_nettype wire

// [design/supply_supervisor_reset_watchdog.sv]
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter bit          HAS_WATCHDOG = 1'b1,
  parameter int unsigned MS_CYCLES    = MS_DIV
) (
  input  wire logic clock_in,
  input  wire logic nrst_in,
  input  wire logic supply_low_in,
  input  wire logic manual_reset_req_n_in,
  input  wire logic power_fail_sense_in,
  input  wire logic watchdog_toggle_in,
  input  wire logic watchdog_float_in,
  output var  logic reset_n_out,
  output var  logic reset_out,
  output var  logic power_fail_flag_n_out,
  output var  logic watchdog_expired_n_out
);
  import supervisor_pkg::*;

  localparam logic [CNT_W-1:0] MS_LAST = CNT_W'(MS_CYCLES - 1);

  // reset pulse phases: held by a trigger, counting out, or released
  typedef enum logic [1:0] {
    RST_HOLD,
    RST_STRETCH,
    RST_DONE
  } rst_phase_t;

  typedef struct packed {
    rst_phase_t       rst_phase;
    logic [CNT_W-1:0] div;
    logic [15:0]      rst_ms;
    logic [15:0]      wd_ms;
    logic             wd_expired;
    logic             toggle_prev;
    logic             reset_n;
    logic             reset_hi;
    logic             pf_n;
    logic             wdo_n;
  } sup_state_t;

  sup_state_t st_q;
  sup_state_t st_d;

  logic supply_low_s;
  logic manual_n_s;
  logic pf_sense_s;
  logic toggle_s;
  logic float_s;

  sync_if sync_sl ();
  sync_if sync_mr ();
  sync_if sync_pf ();
  sync_if sync_tg ();
  sync_if sync_fl ();

  assign sync_sl.d = supply_low_in;
  assign sync_mr.d = manual_reset_req_n_in;
  assign sync_pf.d = power_fail_sense_in;
  assign sync_tg.d = watchdog_toggle_in;
  assign sync_fl.d = watchdog_float_in;
  assign supply_low_s = sync_sl.q;
  assign manual_n_s   = sync_mr.q;
  assign pf_sense_s   = sync_pf.q;
  assign toggle_s     = sync_tg.q;
  assign float_s      = sync_fl.q;

  // all analog and pin flags cross two flip-flops first
  bit_sync u_sync_sl (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .s        (sync_sl)
  );

  bit_sync u_sync_mr (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .s        (sync_mr)
  );

  bit_sync u_sync_pf (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .s        (sync_pf)
  );

  bit_sync u_sync_tg (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .s        (sync_tg)
  );

  bit_sync u_sync_fl (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .s        (sync_fl)
  );

  logic ms_tick;
  logic trigger;
  logic stretch_last;
  logic wd_edge;
  logic wd_last;
  logic wd_clear;
  logic wd_active;

  always_comb begin
    st_d = st_q;

    // millisecond timebase, free running
    ms_tick  = (st_q.div == MS_LAST);
    st_d.div = ms_tick ? DIV_ZERO : st_q.div + DIV_ONE;

    // low supply or a held request keeps the pulse going
    trigger      = supply_low_s || !manual_n_s;
    stretch_last = (st_q.rst_ms == TICK_ONE);

    // reset stretcher; a watchdog timeout is never one of its inputs
    unique case (st_q.rst_phase)
      RST_HOLD: begin
        st_d.rst_ms = RESET_STRETCH_TICKS;
        if (!trigger) begin
          st_d.rst_phase = RST_STRETCH;
        end
      end
      RST_STRETCH: begin
        if (trigger) begin
          // a brownout mid-pulse restarts the full stretch, beyond the extension
          st_d.rst_ms    = RESET_STRETCH_TICKS;
          st_d.rst_phase = RST_HOLD;
        end else if (ms_tick) begin
          st_d.rst_ms = st_q.rst_ms - TICK_ONE;
          if (stretch_last) begin
            st_d.rst_phase = RST_DONE;
          end
        end
      end
      RST_DONE: begin
        st_d.rst_ms = TICKS_ZERO;
        if (trigger) begin
          st_d.rst_ms    = RESET_STRETCH_TICKS;
          st_d.rst_phase = RST_HOLD;
        end
      end
      default: begin
        st_d.rst_ms    = RESET_STRETCH_TICKS;
        st_d.rst_phase = RST_HOLD;
      end
    endcase

    // reset_n follows the next phase; reset_hi does too only when HAS_WATCHDOG is clear, else it stays low
    st_d.reset_n  = (st_d.rst_phase == RST_DONE);
    st_d.reset_hi = HAS_WATCHDOG ? 1'b0 : (st_d.rst_phase != RST_DONE);

    // comparator flag is low while the sense input is high
    st_d.pf_n = !pf_sense_s;

    // watchdog: every edge on the toggle input restarts the count
    st_d.toggle_prev = toggle_s;
    wd_edge   = (toggle_s != st_q.toggle_prev);
    wd_clear  = !st_q.reset_n || float_s || wd_edge;
    wd_active = HAS_WATCHDOG;
    wd_last   = (st_q.wd_ms == WATCHDOG_TICKS - TICK_ONE);
    if (!wd_active || wd_clear) begin
      st_d.wd_ms      = TICKS_ZERO;
      st_d.wd_expired = 1'b0;
    end else if (ms_tick && !st_q.wd_expired) begin
      if (wd_last) begin
        // the count parks here; only a clear releases the output
        st_d.wd_expired = 1'b1;
      end else begin
        st_d.wd_ms = st_q.wd_ms + TICK_ONE;
      end
    end

    // low supply pulls the output low with no minimum width
    st_d.wdo_n = !wd_active || !(st_d.wd_expired || supply_low_s);
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // power-up starts a full stretch, as a released trigger would
      st_q.rst_phase   <= RST_STRETCH;
      st_q.div         <= DIV_ZERO;
      st_q.rst_ms      <= RESET_STRETCH_TICKS;
      st_q.wd_ms       <= TICKS_ZERO;
      st_q.wd_expired  <= 1'b0;
      st_q.toggle_prev <= 1'b0;
      st_q.reset_n     <= 1'b0;
      st_q.reset_hi    <= !HAS_WATCHDOG;
      st_q.pf_n        <= 1'b1;
      st_q.wdo_n       <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // every output is a register field
  assign reset_n_out            = st_q.reset_n;
  assign reset_out              = st_q.reset_hi;
  assign power_fail_flag_n_out  = st_q.pf_n;
  assign watchdog_expired_n_out = st_q.wdo_n;
endmodule // supply_supervisor_reset_watchdog
`default_nettype wire

// [verification/supervisor_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module supervisor_assertions #(
  parameter bit HAS_WATCHDOG = 1'b1
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic supply_low_in,
  input wire logic manual_reset_req_n_in,
  input wire logic power_fail_sense_in,
  input wire logic watchdog_toggle_in,
  input wire logic watchdog_float_in,
  input wire logic reset_n_out,
  input wire logic reset_out,
  input wire logic power_fail_flag_n_out,
  input wire logic watchdog_expired_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  property p_mr; !manual_reset_req_n_in[*5] |-> !reset_n_out; endproperty
  a_mr: assert property (p_mr) else $error("request ignored");
  property p_pfl; power_fail_sense_in[*5] |-> !power_fail_flag_n_out; endproperty
  a_pfl: assert property (p_pfl) else $error("fail flag high");
  property p_pfh; !power_fail_sense_in[*5] |-> power_fail_flag_n_out; endproperty
  a_pfh: assert property (p_pfh) else $error("fail flag low");
  property p_sl; supply_low_in[*5] |-> !reset_n_out && !watchdog_expired_n_out; endproperty
  a_sl: assert property (p_sl) else $error("supply low missed");
  property p_hold; $fell(reset_n_out) |=> !reset_n_out[*8]; endproperty
  a_hold: assert property (p_hold) else $error("pulse short");
  property p_fl; (watchdog_float_in && !supply_low_in)[*5] |-> watchdog_expired_n_out; endproperty
  a_fl: assert property (p_fl) else $error("float timeout");
  property p_nr; (manual_reset_req_n_in && !supply_low_in && reset_n_out)[*4]
    ##0 $fell(watchdog_expired_n_out) |=> reset_n_out; endproperty
  a_nr: assert property (p_nr) else $error("timeout reset");
  property p_ed; $changed(watchdog_toggle_in) && !supply_low_in && watchdog_expired_n_out
    |=> watchdog_expired_n_out[*3]; endproperty
  a_ed: assert property (p_ed) else $error("edge no clear");
  property p_hi; reset_out == (HAS_WATCHDOG ? 1'b0 : !reset_n_out); endproperty
  a_hi: assert property (p_hi) else $error("high reset wrong");
endmodule // supervisor_assertions
bind supply_supervisor_reset_watchdog supervisor_assertions #(.HAS_WATCHDOG(HAS_WATCHDOG))
  supervisor_assertions_inst (
  .clock_in, .nrst_in, .supply_low_in, .manual_reset_req_n_in, .power_fail_sense_in,
  .watchdog_toggle_in, .watchdog_float_in, .reset_n_out, .reset_out, .power_fail_flag_n_out,
  .watchdog_expired_n_out);
`default_nettype wire

// [verification/processor_model.sv]
`timescale 1ns/10ps
`default_nettype none
module processor_model #(parameter int HALF = 1000) (
  input  wire logic clock_in,
  input  wire logic en_in,
  output var  logic toggle_out
);
  int cnt = 0;
  initial toggle_out = 1'h0;
  always @(posedge clock_in) begin
    if (en_in) cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (en_in && cnt == HALF - 1) toggle_out <= #2 !toggle_out;
  end
endmodule // processor_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import supervisor_pkg::*;
  localparam int MS = 4;
  localparam int STR = RESET_STRETCH_MS * MS;
  localparam int WD = WATCHDOG_MS * MS;
  logic clock_in, nrst_in, supply_low_in, manual_reset_req_n_in, power_fail_sense_in;
  logic watchdog_float_in, toggle_en, watchdog_toggle_in, reset_n_out;
  logic power_fail_flag_n_out, watchdog_expired_n_out, reset_out;
  int   mismatches, n_tests, n;
  supply_supervisor_reset_watchdog #(.HAS_WATCHDOG(1'h1), .MS_CYCLES(MS))
    supply_supervisor_reset_watchdog_inst (.clock_in, .nrst_in, .supply_low_in,
    .manual_reset_req_n_in, .power_fail_sense_in, .watchdog_toggle_in, .watchdog_float_in,
    .reset_n_out, .reset_out, .power_fail_flag_n_out, .watchdog_expired_n_out);
  processor_model processor_model_inst (.clock_in, .en_in(toggle_en),
    .toggle_out(watchdog_toggle_in));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock_in);
    #2;
  endtask
  // count cycles until the chosen output reaches v
  task automatic wt(input bit wd, input logic v, input int lim);
    n = 0;
    while (((wd ? watchdog_expired_n_out : reset_n_out) !== v) && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("Error %s expected %b seen %b", wd ? "wdo_wait" : "rst_wait", v,
               wd ? watchdog_expired_n_out : reset_n_out);
      report_and_stop;
    end
  endtask
  task automatic t_mr;
    manual_reset_req_n_in = 1'h0;
    step(10);
    chk("reset_n", 1'h0, reset_n_out);
    chk("rst_hi", 1'h0, reset_out);
    manual_reset_req_n_in = 1'h1;
    wt(0, 1'h1, 2 * STR);
    chk("mr_len", 1'h1, n >= STR - 2 && n <= STR + 6);
    $display("done t_mr");
  endtask
  task automatic t_sup;
    supply_low_in = 1'h1;
    step(20);
    chk("sup_rst", 1'h0, reset_n_out);
    chk("sup_wdo", 1'h0, watchdog_expired_n_out);
    supply_low_in = 1'h0;
    wt(1, 1'h1, 6);
    wt(0, 1'h1, 2 * STR);
    chk("sup_len", 1'h1, n >= STR - 8 && n <= STR + 6);
    $display("done t_sup");
  endtask
  task automatic t_pf;
    power_fail_sense_in = 1'h1;
    step(5);
    chk("pf_low", 1'h0, power_fail_flag_n_out);
    power_fail_sense_in = 1'h0;
    step(5);
    chk("pf_high", 1'h1, power_fail_flag_n_out);
    $display("done t_pf");
  endtask
  task automatic t_wd;
    watchdog_float_in = 1'h0;
    toggle_en = 1'h1;
    step(2 * WD);
    chk("wd_fed", 1'h1, watchdog_expired_n_out);
    toggle_en = 1'h0;
    wt(1, 1'h0, WD + 20);
    chk("wd_time", 1'h1, n >= WD - 1010 && n <= WD + 8);
    chk("wd_norst", 1'h1, reset_n_out);
    step(100);
    chk("wd_stay", 1'h0, watchdog_expired_n_out);
    watchdog_float_in = 1'h1;
    step(WD + 100);
    chk("wd_float", 1'h1, watchdog_expired_n_out);
    $display("done t_wd");
  endtask
  initial begin
    clock_in = 1'h0;
    forever #12.5 clock_in = !clock_in;
  end
  initial begin
    {nrst_in, supply_low_in, power_fail_sense_in, toggle_en} = 4'h0;
    {manual_reset_req_n_in, watchdog_float_in} = 2'h3;
    mismatches = 0;
    n_tests = 0;
    step(8);
    nrst_in = 1'h1;
    wt(0, 1'h1, 2 * STR);
    t_pf;
    t_mr;
    t_sup;
    t_wd;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
